// >>> hw/bah_master.sv
// plug-in bus master: requests, chain pass-through, select ack, service cycle
// What this block does
// - raise request, hold it until acknowledge, then drop it promptly
// - pass chain pulse unchanged when not requesting on the granted level
// - acknowledge on chain pulse while requesting and own grant seen
// - hold acknowledge until own strobe seen, then drop it quickly
// - selected module starts service when strobe seen idle, then strobes
// - drive address and flags on idle bus, remove them with strobe
// - slaves decode address only on leading edge of strobe
// - strobe asserted after address and write data by at least skew
// - remove strobe as soon as completion pulse arrives
// - write data removed with strobe, stable at strobe assertion
// - slave read data precedes completion, released after strobe drops
// - strobe removal at any time disables slave data and completion
// - slave completion pulse is 40 to 60 ns
// - read-modify-write holds strobe over both halves, two completions
// - in read-modify-write slave drops read data soon after completion
// - half-cycle flag only in read half; write flag starts write half
`default_nettype none
`include "bah_regs.svh"

module bah_master #(
  parameter int LEVEL      = 0,
  parameter int DELAY_CYC  = `BAH_TRANSFER_STROBE_DELAY_CYC
) (
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      cmd_valid_in,
  input  wire bah_pkg::bah_cmd_t         cmd_in,
  output logic                           cmd_ready_out,
  output logic                           resp_valid_out,
  output logic                           resp_error_out,
  output logic [`BAH_DATA_W-1:0]         resp_rdata_out,
  input  wire bah_pkg::bah_bus_in_t      bus_in,
  output bah_pkg::bah_bus_out_t          bus_out
);

  localparam logic [`BAH_TMR_W-1:0] DELAY_LOAD = DELAY_CYC[`BAH_TMR_W-1:0];

  bah_pkg::bah_state_reg_t regs_ff;
  bah_pkg::bah_state_reg_t nxt_regs;
  logic                    tmr_start;
  logic                    tmr_expired;
  logic                    chain_rise;
  logic                    done_rise;
  logic                    own_grant;
  logic                    requesting;

  // delay from address gating to strobe
  bah_delay #(
    .W           (`BAH_TMR_W)
  ) u_delay (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .start_in    (tmr_start),
    .count_in    (DELAY_LOAD),
    .expired_out (tmr_expired)
  );

  // edge views of the asynchronous handshake lines, plus our grant and request levels
  assign chain_rise = bus_in.chain_pulse_in && !regs_ff.chain_q;
  assign done_rise  = bus_in.completion && !regs_ff.done_q;
  assign own_grant  = bus_in.bus_grant[LEVEL];
  assign requesting = regs_ff.bus.bus_request[LEVEL];

  // next-state logic for the whole master
  always_comb begin
    nxt_regs            = regs_ff;
    tmr_start           = 1'b0;
    nxt_regs.chain_q    = bus_in.chain_pulse_in;
    nxt_regs.done_q     = bus_in.completion;
    nxt_regs.resp_valid = 1'b0;
    nxt_regs.resp_error = 1'b0;
    // chain passes through a single registered gate unless we claim it
    nxt_regs.bus.chain_pulse_out = bus_in.chain_pulse_in &&
                                   !(requesting && own_grant);

    unique case (regs_ff.state)
      bah_pkg::BAH_IDLE: begin
        if (cmd_valid_in && regs_ff.cmd_ready) begin
          nxt_regs.cmd                     = cmd_in;
          nxt_regs.cmd_ready               = 1'b0;
          nxt_regs.write_half              = 1'b0;
          nxt_regs.bus.bus_request[LEVEL]  = 1'b1;
          nxt_regs.state                   = bah_pkg::BAH_SELECT;
        end
      end
      bah_pkg::BAH_SELECT: begin
        // claim the chain pulse when our level is granted
        if (chain_rise && own_grant) begin
          nxt_regs.bus.select_acknowledge = 1'b1;
          nxt_regs.bus.bus_request        = '0;
          nxt_regs.state                  = bah_pkg::BAH_WAIT_BUS;
        end
      end
      bah_pkg::BAH_WAIT_BUS: begin
        // bus idle: gate address, flags and write data together
        if (!bus_in.transfer_strobe) begin
          nxt_regs.bus.address_lines   = regs_ff.cmd.addr;
          nxt_regs.bus.address_oe      = 1'b1;
          nxt_regs.bus.write_flag      = regs_ff.cmd.write &&
                                         !regs_ff.cmd.read_modify_write;
          nxt_regs.bus.byte_flag       = regs_ff.cmd.byte_mode;
          nxt_regs.bus.half_cycle_flag = regs_ff.cmd.read_modify_write;
          nxt_regs.bus.flags_oe        = 1'b1;
          nxt_regs.bus.data_lines      = regs_ff.cmd.wdata;
          nxt_regs.bus.data_oe         = regs_ff.cmd.write &&
                                         !regs_ff.cmd.read_modify_write;
          tmr_start                    = 1'b1;
          nxt_regs.state               = bah_pkg::BAH_SETUP;
        end
      end
      bah_pkg::BAH_SETUP: begin
        // strobe goes last, after the skew delay
        if (tmr_expired) begin
          nxt_regs.bus.transfer_strobe = 1'b1;
          nxt_regs.state               = bah_pkg::BAH_STROBE;
        end
      end
      bah_pkg::BAH_STROBE, bah_pkg::BAH_WR_HALF: begin
        // release acknowledge once our own strobe is seen on the bus
        if (bus_in.transfer_strobe) begin
          nxt_regs.bus.select_acknowledge = 1'b0;
        end
        if (done_rise) begin
          if (!regs_ff.write_half && !regs_ff.cmd.write) begin
            nxt_regs.rdata = bus_in.data_lines;
          end
          if (regs_ff.cmd.read_modify_write && !regs_ff.write_half) begin
            // strobe stays up into the write half
            nxt_regs.bus.half_cycle_flag = 1'b0;
            nxt_regs.state               = bah_pkg::BAH_RMW_GAP;
          end else begin
            nxt_regs.bus.transfer_strobe = 1'b0;
            nxt_regs.bus.address_oe      = 1'b0;
            nxt_regs.bus.flags_oe        = 1'b0;
            nxt_regs.bus.write_flag      = 1'b0;
            nxt_regs.bus.byte_flag       = 1'b0;
            nxt_regs.bus.data_oe         = 1'b0;
            nxt_regs.bus.select_acknowledge = 1'b0;
            nxt_regs.resp_valid          = 1'b1;
            nxt_regs.cmd_ready           = 1'b1;
            nxt_regs.state               = bah_pkg::BAH_IDLE;
          end
        end
      end
      bah_pkg::BAH_RMW_GAP: begin
        // wait for the read completion to end, then place write data
        if (!bus_in.completion) begin
          nxt_regs.bus.data_lines = regs_ff.cmd.wdata;
          nxt_regs.bus.data_oe    = 1'b1;
          nxt_regs.write_half     = 1'b1;
          tmr_start               = 1'b1;
          nxt_regs.state          = bah_pkg::BAH_WR_SETUP;
        end
      end
      bah_pkg::BAH_WR_SETUP: begin
        // write flag opens the write half once data has settled
        if (tmr_expired) begin
          nxt_regs.bus.write_flag = 1'b1;
          nxt_regs.state          = bah_pkg::BAH_WR_HALF;
        end
      end
    endcase

    // quit from the controller aborts a transfer in any state past BAH_SELECT
    if (bus_in.quit && regs_ff.state != bah_pkg::BAH_IDLE &&
        regs_ff.state != bah_pkg::BAH_SELECT) begin
      nxt_regs.bus.transfer_strobe    = 1'b0;
      nxt_regs.bus.select_acknowledge = 1'b0;
      nxt_regs.bus.address_oe         = 1'b0;
      nxt_regs.bus.flags_oe           = 1'b0;
      nxt_regs.bus.write_flag         = 1'b0;
      nxt_regs.bus.byte_flag          = 1'b0;
      nxt_regs.bus.half_cycle_flag    = 1'b0;
      nxt_regs.bus.data_oe            = 1'b0;
      nxt_regs.bus.bus_request        = '0;
      nxt_regs.resp_error             = 1'b1;
      nxt_regs.cmd_ready              = 1'b1;
      nxt_regs.state                  = bah_pkg::BAH_IDLE;
      tmr_start                       = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      regs_ff           <= '0;
      regs_ff.state     <= bah_pkg::BAH_IDLE;
      regs_ff.cmd_ready <= 1'b1;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // outputs straight from the state register
  assign cmd_ready_out  = regs_ff.cmd_ready;
  assign resp_valid_out = regs_ff.resp_valid;
  assign resp_error_out = regs_ff.resp_error;
  assign resp_rdata_out = regs_ff.rdata;
  assign bus_out        = regs_ff.bus;

endmodule

`default_nettype wire

// >>> shared/bah_regs.svh
// timing counts and widths for the backplane arbitration handshake master
`ifndef BAH_REGS_SVH
`define BAH_REGS_SVH

`define BAH_ADDR_W          16
`define BAH_DATA_W          16
`define BAH_NUM_LEVELS      5
`define BAH_CLK_PERIOD_NS   40
// strobe delay after address, data and flags (longer than 25 ns skew)
`define BAH_SKEW_NS         25
`define BAH_TRANSFER_STROBE_DELAY_NS   50
`define BAH_TRANSFER_STROBE_DELAY_CYC  ((`BAH_TRANSFER_STROBE_DELAY_NS + `BAH_CLK_PERIOD_NS - 1) / `BAH_CLK_PERIOD_NS)
`define BAH_TMR_W           4

`endif

// >>> shared/bah_pkg.sv
// types shared by the backplane arbitration handshake master
`default_nettype none
`include "bah_regs.svh"

package bah_pkg;

  typedef enum logic [3:0] {
    BAH_IDLE,
    BAH_SELECT,
    BAH_WAIT_BUS,
    BAH_SETUP,
    BAH_STROBE,
    BAH_RMW_GAP,
    BAH_WR_SETUP,
    BAH_WR_HALF
  } bah_state_t;

  // one transfer asked for by the user side
  typedef struct packed {
    logic [`BAH_ADDR_W-1:0] addr;
    logic [`BAH_DATA_W-1:0] wdata;
    logic                   write;
    logic                   byte_mode;
    logic                   read_modify_write;
  } bah_cmd_t;

  // lines driven onto the backplane, asserted high (receiver inverts)
  typedef struct packed {
    logic [`BAH_NUM_LEVELS-1:0] bus_request;
    logic                       select_acknowledge;
    logic                       transfer_strobe;
    logic                       chain_pulse_out;
    logic [`BAH_ADDR_W-1:0]     address_lines;
    logic                       address_oe;
    logic [`BAH_DATA_W-1:0]     data_lines;
    logic                       data_oe;
    logic                       write_flag;
    logic                       byte_flag;
    logic                       half_cycle_flag;
    logic                       flags_oe;
  } bah_bus_out_t;

  // lines seen on the backplane, asserted high
  typedef struct packed {
    logic [`BAH_NUM_LEVELS-1:0] bus_grant;
    logic                       chain_pulse_in;
    logic                       select_acknowledge;
    logic                       transfer_strobe;
    logic                       completion;
    logic                       quit;
    logic [`BAH_DATA_W-1:0]     data_lines;
  } bah_bus_in_t;

  // whole state of the master
  typedef struct packed {
    bah_state_t             state;
    bah_cmd_t               cmd;
    logic                   write_half;
    logic                   chain_q;
    logic                   done_q;
    logic                   cmd_ready;
    logic                   resp_valid;
    logic                   resp_error;
    logic [`BAH_DATA_W-1:0] rdata;
    bah_bus_out_t           bus;
  } bah_state_reg_t;

endpackage

`default_nettype wire

// >>> hw/bah_delay.sv
// down-counter that marks when a programmed number of cycles has elapsed
`default_nettype none

module bah_delay #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] count_in,
  output logic              expired_out
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         armed;
  } bah_delay_state_t;

  bah_delay_state_t state_ff;
  bah_delay_state_t nxt_state;

  // load on start, then count down to zero and hold
  always_comb begin
    nxt_state = state_ff;
    if (start_in) begin
      nxt_state.count = count_in;
      nxt_state.armed = 1'b1;
    end else if (state_ff.count != '0) begin
      nxt_state.count = state_ff.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // level while armed and run out, until the next start
  assign expired_out = state_ff.armed && (state_ff.count == '0) && !start_in;

endmodule

`default_nettype wire

// >>> testbench/bah_master_props.sv
// checker for the backplane bus master's handshake ports
`default_nettype none
module bah_master_props #(
  parameter int LEVEL = 0
) (
  input wire logic                  clk_in,
  input wire logic                  rst_b_in,
  input wire bah_pkg::bah_bus_in_t  bus_in,
  input wire bah_pkg::bah_bus_out_t bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // select phase: request, chain gate and acknowledge
  a_req_held: assert property (
    $fell(bus_out.bus_request[LEVEL]) |-> bus_out.select_acknowledge)
    else $error("request dropped early");
  a_chain_pass: assert property (
    !$past(bus_out.bus_request[LEVEL] && bus_in.bus_grant[LEVEL])
    |-> bus_out.chain_pulse_out == $past(bus_in.chain_pulse_in))
    else $error("chain pulse not passed");
  a_ack_on_chain: assert property (
    bus_out.bus_request[LEVEL] && bus_in.bus_grant[LEVEL]
    && bus_in.chain_pulse_in |=> bus_out.select_acknowledge)
    else $error("no acknowledge");
  a_ack_drop: assert property (
    bus_out.select_acknowledge && bus_out.transfer_strobe
    && bus_in.transfer_strobe |=> !bus_out.select_acknowledge)
    else $error("acknowledge held");
  // service phase: start on idle bus, strobe last, release on completion
  a_idle_start: assert property (
    $rose(bus_out.address_oe) |-> !$past(bus_in.transfer_strobe))
    else $error("started on busy bus");
  a_transfer_strobe_late: assert property (
    $rose(bus_out.transfer_strobe)
    |-> $past(bus_out.address_oe, 2) && bus_out.flags_oe)
    else $error("strobe before address");
  a_transfer_strobe_drop: assert property (
    $rose(bus_in.completion) && !bus_out.half_cycle_flag
    |=> !bus_out.transfer_strobe && !bus_out.address_oe && !bus_out.data_oe)
    else $error("strobe not released");
  a_rmw_hold: assert property (
    $rose(bus_in.completion) && bus_out.half_cycle_flag
    |=> bus_out.transfer_strobe && !bus_out.half_cycle_flag)
    else $error("read half not held");
endmodule
`default_nettype wire

// >>> testbench/bah_bus_model.sv
// bus controller and one-word slave facing the bus master
`default_nettype none
`include "bah_regs.svh"
module bah_bus_model #(
  parameter int SELF_ACK = 25,
  parameter int QUIT_CYC = 50
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  other_req_in,
  input  wire logic                  mute_in,
  input  wire logic                  other_stb_in,
  input  wire bah_pkg::bah_bus_out_t dut_in,
  output bah_pkg::bah_bus_in_t       ctl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]             req, pick, gnt_ff;
  logic [6:0]             sel_ff, cyc_ff;
  logic [1:0]             dly_ff;
  logic [`BAH_DATA_W-1:0] mem_ff;
  logic                   chain_ff, sent_ff, select_acknowledge_ff, comp_ff, off_ff;
  logic                   quit_ff, stb_q, wr_q, ack, stb, start;
  assign req = dut_in.bus_request | {1'b0, other_req_in, 3'h0};
  assign ack = dut_in.select_acknowledge | select_acknowledge_ff;
  assign stb = dut_in.transfer_strobe;
  assign start = stb & (!stb_q | (dut_in.write_flag & !wr_q));
  // highest requesting level wins, one grant only
  always_comb begin
    pick = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (req[i]) pick = 5'h01 << i;
    end
  end
  // grant and slave delay reset; the rest except mem_ff settles from them within 4 cycles
  always_ff @(posedge clk_in) begin
    gnt_ff <= !rst_b_in || ack ? 5'h00
            : (gnt_ff == 5'h00 ? pick : gnt_ff);
    sent_ff <= gnt_ff != 5'h00;
    chain_ff <= gnt_ff != 5'h00 && !sent_ff;
    sel_ff <= gnt_ff != 5'h00 ? sel_ff + 7'h01 : 7'h00;
    select_acknowledge_ff <= gnt_ff != 5'h00 && sel_ff >= SELF_ACK;
    cyc_ff <= stb | ack ? cyc_ff + 7'h01 : 7'h00;
    quit_ff <= (stb | ack) && cyc_ff >= QUIT_CYC;
    stb_q <= stb;
    wr_q <= dut_in.write_flag;
    dly_ff <= !rst_b_in ? 2'h3
            : start ? 2'h1 : (dly_ff == 2'h3 ? dly_ff : dly_ff + 2'h1);
    comp_ff <= stb && dly_ff == 2'h2 && !mute_in;
    off_ff <= stb && (off_ff || comp_ff);
    if (stb && dly_ff == 2'h2 && dut_in.write_flag) mem_ff <= dut_in.data_lines;
  end
  // lines seen by the master; released data reads as the idle level
  assign ctl_out.bus_grant = gnt_ff;
  assign ctl_out.chain_pulse_in = chain_ff;
  assign ctl_out.select_acknowledge = ack;
  // another master's cycle still on the bus shows as a foreign strobe
  assign ctl_out.transfer_strobe = stb | other_stb_in;
  assign ctl_out.completion = comp_ff & stb;
  assign ctl_out.quit = quit_ff;
  assign ctl_out.data_lines = stb && !dut_in.write_flag && !off_ff ?
                              mem_ff : 16'h0000;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the backplane bus master
`default_nettype none
`include "bah_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_in, rst_b_in, cmd_valid_in, other_req, mute;
  logic                   cmd_ready_out, resp_valid_out, resp_error_out;
  logic                   chain_seen, got_ok, got_err;
  logic                   other_stb, transfer_strobe_q, byte_sel, byte_seen;
  logic [`BAH_DATA_W-1:0] resp_rdata_out;
  logic [`BAH_ADDR_W-1:0] addr_seen;
  bah_pkg::bah_cmd_t      cmd_in;
  bah_pkg::bah_bus_in_t   bus_in;
  bah_pkg::bah_bus_out_t  bus_out;
  int                     n_mismatch, n_tests, cycles;
  bah_master #(.LEVEL(1), .DELAY_CYC(1)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .resp_valid_out(resp_valid_out), .resp_error_out(resp_error_out),
    .resp_rdata_out(resp_rdata_out), .bus_in(bus_in), .bus_out(bus_out));
  bah_bus_model u_bus (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .other_req_in(other_req),
    .mute_in(mute), .other_stb_in(other_stb), .dut_in(bus_out),
    .ctl_out(bus_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // hang guard and a watch for chain pulses passed on
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    transfer_strobe_q <= bus_out.transfer_strobe;
    // address and byte flag as a slave takes them at the strobe leading edge
    if (bus_out.transfer_strobe === 1'b1 && transfer_strobe_q !== 1'b1) begin
      addr_seen <= bus_out.address_lines;
      byte_seen <= bus_out.byte_flag;
    end
    if (bus_out.chain_pulse_out === 1'b1) chain_seen <= 1'b1;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // offer one command, then wait for its answer
  task automatic xfer(logic [15:0] a, logic [15:0] d, logic w, logic m);
    @(posedge clk_in);
    cmd_in <= '{a, d, w, byte_sel, m};
    cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    got_ok = 1'b0;
    got_err = 1'b0;
    for (int i = 0; i < 300 && !got_ok && !got_err; i++) begin
      @(posedge clk_in);
      got_ok = resp_valid_out === 1'b1;
      got_err = resp_error_out === 1'b1;
    end
  endtask
  task automatic t_write_read();
    xfer(16'h0010, 16'h5A3C, 1'b1, 1'b0);
    chk("write done", 16'h0001, {15'h0000, got_ok});
    chk("ready back", 16'h0001, {15'h0000, cmd_ready_out});
    chk("write address", 16'h0010, addr_seen);
    chk("word flag", 16'h0000, {15'h0000, byte_seen});
    byte_sel = 1'b1;
    xfer(16'h0010, 16'h0000, 1'b0, 1'b0);
    byte_sel = 1'b0;
    chk("read data", 16'h5A3C, resp_rdata_out);
    chk("byte flag", 16'h0001, {15'h0000, byte_seen});
  endtask
  task automatic t_rmw();
    xfer(16'h0010, 16'hC3E1, 1'b0, 1'b1);
    chk("rmw old data", 16'h5A3C, resp_rdata_out);
    xfer(16'h0010, 16'h0000, 1'b0, 1'b0);
    chk("rmw new data", 16'hC3E1, resp_rdata_out);
  endtask
  // a higher card wins first; nobody answers it, so the controller does
  task automatic t_contend();
    chain_seen = 1'b0;
    other_req <= 1'b1;
    other_stb <= 1'b1;
    fork
      xfer(16'h0020, 16'h0000, 1'b0, 1'b0);
      begin
        wait (bus_in.select_acknowledge === 1'b1);
        @(posedge clk_in);
        other_req <= 1'b0;
      end
      // a foreign cycle still runs: the selected master must wait for it
      begin
        wait (bus_out.select_acknowledge === 1'b1);
        repeat (4) @(posedge clk_in);
        chk("bus wait", 16'h0000, {15'h0000, bus_out.address_oe});
        other_stb <= 1'b0;
      end
    join
    chk("contend done", 16'h0001, {15'h0000, got_ok});
    chk("contend address", 16'h0020, addr_seen);
    chk("chain passed", 16'h0001, {15'h0000, chain_seen});
    chk("read after self ack", 16'hC3E1, resp_rdata_out);
  endtask
  // slave stays silent until the cycle timeout aborts the transfer
  task automatic t_quit();
    mute <= 1'b1;
    xfer(16'h0030, 16'h0000, 1'b0, 1'b0);
    chk("quit error", 16'h0001, {15'h0000, got_err});
    mute <= 1'b0;
    xfer(16'h0030, 16'h0000, 1'b0, 1'b0);
    chk("read done", 16'h0001, {15'h0000, got_ok});
    chk("read after quit", 16'hC3E1, resp_rdata_out);
  endtask
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_b_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    other_req = 1'b0;
    mute = 1'b0;
    other_stb = 1'b0;
    byte_sel = 1'b0;
    chain_seen = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_write_read();
    t_rmw();
    t_contend();
    t_quit();
    complete_run();
  end
endmodule
bind bah_master bah_master_props #(.LEVEL(LEVEL)) u_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in), .bus_out(bus_out));
`default_nettype wire
